// File: logic/ifl_core.sv
// Interrupt flag logic: event flags, enables, wake-up and Wishbone register slave
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module ifl_core
    import ifl_pkg::*;
(
    input wire logic clock,                 // Instruction-cycle clock
    input wire logic srst,                  // Synchronous reset, active high
    input wire logic wb_cyc_i,              // Wishbone cycle
    input wire logic wb_stb_i,              // Wishbone strobe
    input wire logic wb_we_i,               // Wishbone write enable
    input wire logic [IFL_ADDR_W-1:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i,        // Wishbone byte selects
    input wire logic [IFL_DATA_W-1:0] wb_dat_i, // Wishbone write data
    output logic [IFL_DATA_W-1:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o,                  // Wishbone acknowledge
    input wire logic ext_event_pin,         // External event pin
    input wire logic [3:0] upper_nibble_port_pins, // Port bits 7 to 4
    input wire logic timer_tick,            // Timer advance pulse
    input wire logic vector_taken,          // Core entered the vector, clears global enable while running (ignored in sleep and wake)
    output logic irq_request,               // Interrupt request to the core
    output logic sleeping,                  // Core held in power-down
    output logic wake_pulse,                // One-cycle wake from power-down
    output logic wake_to_vector             // With wake_pulse: branch to vector
);
    typedef struct packed {
        logic [7:0] evctl;
        logic edge_sel;
        ifl_pwr_t pwr;
        logic ext_en_at_sleep;
        logic ack;
        logic [IFL_DATA_W-1:0] rdat;
        logic wake;
        logic wake_vec;
    } ifl_core_t;
    ifl_core_t s_q;
    ifl_core_t s_d;
    ifl_evt_if evt ();
    logic wr_hit;
    logic rd_hit;
    logic [7:0] wr_byte;
    logic pend_ext;
    logic pend_tmr;
    logic pend_port;
    logic any_pend;
    logic ext_wake;
    ifl_event_detect u_detect (
        .clock(clock),
        .srst(srst),
        .ext_event_pin(ext_event_pin),
        .upper_nibble_port_pins(upper_nibble_port_pins),
        .edge_polarity_select(s_q.edge_sel),
        .timer_tick(timer_tick),
        .evt(evt.det)
    );
    assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & ~s_q.ack & wb_sel_i[0];
    assign rd_hit = wb_cyc_i & wb_stb_i & ~wb_we_i & ~s_q.ack;
    assign wr_byte = wb_dat_i[7:0];
    assign pend_ext = s_q.evctl[IFL_EXT_FLAG_BIT] & s_q.evctl[IFL_EXT_EN_BIT];
    assign pend_tmr = s_q.evctl[IFL_TMR_FLAG_BIT] & s_q.evctl[IFL_TMR_EN_BIT];
    assign pend_port = s_q.evctl[IFL_PORT_FLAG_BIT] & s_q.evctl[IFL_PORT_EN_BIT];
    assign any_pend = pend_ext | pend_tmr | pend_port;
    // Wake uses the enable latched on entry, so enabling it late while asleep has no effect
    assign ext_wake = s_q.ext_en_at_sleep & s_q.evctl[IFL_EXT_FLAG_BIT];
    always_comb
    begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.wake = 1'b0;
        s_d.wake_vec = 1'b0;
        if (wr_hit)
        begin
            if (wb_adr_i == IFL_EVCTL_OFS)
            begin
                s_d.evctl = wr_byte;
            end
            else if (wb_adr_i == IFL_OPT_OFS)
            begin
                s_d.edge_sel = wr_byte[IFL_EDGE_SEL_BIT];
                if (wr_byte[IFL_SLEEP_BIT] && s_q.pwr == IFL_RUN)
                begin
                    s_d.pwr = IFL_SLEEP;
                    s_d.ext_en_at_sleep = s_q.evctl[IFL_EXT_EN_BIT];
                end
            end
        end
        if (wb_cyc_i && wb_stb_i && !s_q.ack)
        begin
            s_d.ack = 1'b1;
        end
        if (rd_hit)
        begin
            if (wb_adr_i == IFL_EVCTL_OFS)
            begin
                s_d.rdat = {24'h000000, s_q.evctl};
            end
            else if (wb_adr_i == IFL_OPT_OFS)
            begin
                s_d.rdat = {25'h0, s_q.edge_sel, 5'h00, s_q.pwr == IFL_SLEEP};
            end
            else if (wb_adr_i == IFL_STAT_OFS)
            begin
                s_d.rdat = {16'h0000, evt.timer_count, any_pend, 2'h0,
                            upper_nibble_port_pins, ext_event_pin};
            end
            else
            begin
                s_d.rdat = IFL_UNMAPPED_RD;
            end
        end
        // Hardware set wins over a same-cycle software clear
        if (evt.ext_edge)
        begin
            s_d.evctl[IFL_EXT_FLAG_BIT] = 1'b1;
        end
        if (evt.timer_wrap)
        begin
            s_d.evctl[IFL_TMR_FLAG_BIT] = 1'b1;
        end
        if (evt.port_change)
        begin
            s_d.evctl[IFL_PORT_FLAG_BIT] = 1'b1;
        end
        if (vector_taken && s_q.pwr == IFL_RUN)
        begin
            s_d.evctl[IFL_GLOBAL_EN_BIT] = 1'b0;
        end
        case (s_q.pwr)
            IFL_SLEEP:
            begin
                if (ext_wake)
                begin
                    s_d.pwr = IFL_WAKE;
                end
            end
            IFL_WAKE:
            begin
                s_d.pwr = IFL_RUN;
                s_d.wake = 1'b1;
                s_d.wake_vec = s_q.evctl[IFL_GLOBAL_EN_BIT];
            end
            default:
            begin
            end
        endcase
    end
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            s_q.evctl <= IFL_EVCTL_RST;
            s_q.edge_sel <= IFL_EDGE_SEL_RST;
            s_q.pwr <= IFL_RUN;
            s_q.ext_en_at_sleep <= 1'b0;
            s_q.ack <= 1'b0;
            s_q.rdat <= '0;
            s_q.wake <= 1'b0;
            s_q.wake_vec <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdat;
    // Request is held off while asleep; wake_to_vector carries the branch decision instead
    assign irq_request = s_q.evctl[IFL_GLOBAL_EN_BIT] & any_pend & (s_q.pwr == IFL_RUN);
    assign sleeping = (s_q.pwr != IFL_RUN);
    assign wake_pulse = s_q.wake;
    assign wake_to_vector = s_q.wake_vec;

    a_ext_flag_set: assert property (@(posedge clock) disable iff (srst)
        evt.ext_edge |=> s_q.evctl[IFL_EXT_FLAG_BIT])
        else $error("external flag not set");
    a_ext_mask: assert property (@(posedge clock) disable iff (srst)
        !s_q.evctl[IFL_EXT_EN_BIT] && !pend_tmr && !pend_port |-> !irq_request)
        else $error("masked external event raised request");
    a_flag_sticky: assert property (@(posedge clock) disable iff (srst)
        s_q.evctl[IFL_EXT_FLAG_BIT] && !(wr_hit && wb_adr_i == IFL_EVCTL_OFS)
            |=> s_q.evctl[IFL_EXT_FLAG_BIT])
        else $error("external flag dropped without write");
    a_wake_gate: assert property (@(posedge clock) disable iff (srst)
        s_q.pwr == IFL_SLEEP && !s_q.ext_en_at_sleep |=> s_q.pwr != IFL_WAKE)
        else $error("wake without prior enable");
    a_wake_vector: assert property (@(posedge clock) disable iff (srst)
        s_q.pwr == IFL_WAKE |=> wake_pulse
            && (wake_to_vector == $past(s_q.evctl[IFL_GLOBAL_EN_BIT])))
        else $error("wake vector decision wrong");
    a_tmr_flag: assert property (@(posedge clock) disable iff (srst)
        evt.timer_wrap |=> s_q.evctl[IFL_TMR_FLAG_BIT])
        else $error("timer flag not set");
    a_tmr_mask: assert property (@(posedge clock) disable iff (srst)
        pend_tmr && s_q.evctl[IFL_GLOBAL_EN_BIT] && s_q.pwr == IFL_RUN |-> irq_request)
        else $error("timer request missing");
    a_port_flag: assert property (@(posedge clock) disable iff (srst)
        evt.port_change |=> s_q.evctl[IFL_PORT_FLAG_BIT])
        else $error("port flag not set");
    a_port_mask: assert property (@(posedge clock) disable iff (srst)
        irq_request |-> pend_ext || pend_tmr || (s_q.evctl[0] && s_q.evctl[3]))
        else $error("request with no enabled flag");
    a_global_gate: assert property (@(posedge clock) disable iff (srst)
        !s_q.evctl[IFL_GLOBAL_EN_BIT] |-> !irq_request)
        else $error("request with global enable clear");
    c_ext_irq: cover property (@(posedge clock) disable iff (srst)
        evt.ext_edge ##1 irq_request);
    c_tmr_wrap: cover property (@(posedge clock) disable iff (srst) evt.timer_wrap);
    c_wake_vec: cover property (@(posedge clock) disable iff (srst) wake_pulse && wake_to_vector);
    c_wake_plain: cover property (@(posedge clock) disable iff (srst)
        wake_pulse && !wake_to_vector);
endmodule

// File: logic/ifl_event_detect.sv
// Edge, port-change and timer-wrap detection for the interrupt flag block
`timescale 1ns/1ps
module ifl_event_detect
    import ifl_pkg::*;
(
    input wire logic clock,          // Instruction-cycle clock
    input wire logic srst,           // Synchronous reset, active high
    input wire logic ext_event_pin,  // External event pin
    input wire logic [3:0] upper_nibble_port_pins, // Port bits 7 to 4
    input wire logic edge_polarity_select, // 1 rising, 0 falling
    input wire logic timer_tick,     // Advances the eight_bit_timer
    ifl_evt_if.det evt               // Detected events
);
    typedef struct packed {
        logic pin;
        logic [3:0] port;
        logic [7:0] tmr;
        logic prime;
    } ifl_det_t;
    ifl_det_t s_q;
    ifl_det_t s_d;
    always_comb
    begin
        s_d = s_q;
        s_d.pin = ext_event_pin;
        s_d.port = upper_nibble_port_pins;
        s_d.prime = 1'b1;
        if (timer_tick)
        begin
            s_d.tmr = s_q.tmr + 8'h01;
        end
    end
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    // Inputs are one instruction cycle wide at least, so one sample per cycle catches them
    assign evt.ext_edge = s_q.prime & (edge_polarity_select ? (ext_event_pin & ~s_q.pin)
                                                            : (~ext_event_pin & s_q.pin));
    assign evt.port_change = s_q.prime & (upper_nibble_port_pins != s_q.port);
    assign evt.timer_wrap = timer_tick & (s_q.tmr == IFL_TMR_MAX);
    assign evt.timer_count = s_q.tmr;
    a_edge_rise: assert property (@(posedge clock) disable iff (srst)
        (s_q.prime && edge_polarity_select && ext_event_pin && !$past(ext_event_pin)
            && !$past(srst)) |-> evt.ext_edge)
        else $error("rising edge missed");
    a_wrap_zero: assert property (@(posedge clock) disable iff (srst)
        evt.timer_wrap |=> (s_q.tmr == IFL_TMR_ZERO))
        else $error("timer wrap not to zero");
endmodule

// File: logic/ifl_evt_if.sv
// Interface: detected pin and timer events passed from the detector to the register core
`timescale 1ns/1ps
interface ifl_evt_if;
    logic ext_edge;
    logic port_change;
    logic timer_wrap;
    logic [7:0] timer_count;
    modport det (output ext_edge, output port_change, output timer_wrap, output timer_count);
    modport core (input ext_edge, input port_change, input timer_wrap, input timer_count);
endinterface

// File: logic/ifl_pkg.sv
// Package: register map, field positions and reset values of the interrupt flag block
package ifl_pkg;
    localparam int IFL_ADDR_W = 4;
    localparam int IFL_DATA_W = 32;
    // Register byte offsets on the Wishbone slave
    localparam logic [IFL_ADDR_W-1:0] IFL_EVCTL_OFS = 4'h0;  // event_control_register
    localparam logic [IFL_ADDR_W-1:0] IFL_OPT_OFS = 4'h4;    // edge polarity and power-down
    localparam logic [IFL_ADDR_W-1:0] IFL_STAT_OFS = 4'h8;   // live pins, timer count and pending status
    // Event control register fields
    localparam int IFL_PORT_FLAG_BIT = 0;
    localparam int IFL_EXT_FLAG_BIT = 1;
    localparam int IFL_TMR_FLAG_BIT = 2;
    localparam int IFL_PORT_EN_BIT = 3;
    localparam int IFL_EXT_EN_BIT = 4;
    localparam int IFL_TMR_EN_BIT = 5;
    localparam int IFL_GLOBAL_EN_BIT = 7;
    // Option register fields
    localparam int IFL_EDGE_SEL_BIT = 6;
    localparam int IFL_SLEEP_BIT = 0;
    // Reset values, timer limits and unmapped read value
    localparam logic [7:0] IFL_EVCTL_RST = 8'h00;
    localparam logic IFL_EDGE_SEL_RST = 1'b1;
    localparam logic [7:0] IFL_TMR_MAX = 8'hff;
    localparam logic [7:0] IFL_TMR_ZERO = 8'h00;
    localparam logic [31:0] IFL_UNMAPPED_RD = 32'h0000_0000;
    typedef enum logic [1:0] {
        IFL_RUN = 2'b00,
        IFL_SLEEP = 2'b01,
        IFL_WAKE = 2'b10
    } ifl_pwr_t;
endpackage

// File: verification/ifl_core_model.sv
// Processor core stand-in that enters the interrupt vector when allowed
`timescale 1ns/1ps
module ifl_core_model
(
    input wire logic clock,       // Instruction-cycle clock
    input wire logic srst,        // Synchronous reset, active high
    input wire logic irq_request, // Request from the block
    input wire logic accept,      // Core may enter the vector
    output logic vector_taken     // One-cycle vector entry pulse
);
    // One pulse per entry, so the global enable is cleared only once
    always_ff @(posedge clock)
    begin
        if (srst)
            vector_taken <= 1'b0;
        else
            vector_taken <= irq_request & accept & ~vector_taken;
    end
endmodule

// File: verification/interrupt_flag_logic_bench.sv
// Self-checking bench for the interrupt flag block
`timescale 1ns/1ps
module interrupt_flag_logic_bench;
    import ifl_pkg::*;
    logic clock = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [IFL_ADDR_W-1:0] adr = '0;
    logic [IFL_DATA_W-1:0] wdat = '0, rdat, q;
    logic ack, vec, irq, sleeping, wake, wvec;
    logic pin = 1'b0, tick = 1'b0, accept = 1'b0, woke_vec = 1'b0;
    int wakes = 0;
    logic [3:0] port = 4'h0;
    int mismatches = 0;
    int num_checks = 0;

    ifl_core ifl_core_inst (.clock(clock), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ext_event_pin(pin), .upper_nibble_port_pins(port),
        .timer_tick(tick), .vector_taken(vec), .irq_request(irq), .sleeping(sleeping),
        .wake_pulse(wake), .wake_to_vector(wvec));
    ifl_core_model ifl_core_model_inst (.clock(clock), .srst(srst), .irq_request(irq),
        .accept(accept), .vector_taken(vec));

    initial
    begin
        forever #5 clock = ~clock;
    end

    // Wake is a single-cycle pulse, so keep it until a scenario looks
    always @(posedge clock)
    begin
        if (wake === 1'b1)
        begin
            wakes <= wakes + 1;
            woke_vec <= wvec;
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do
        begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1)
        begin
            mismatches++;
            wrap_up();
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 8'h00);
        check(q, exp, what);
    endtask

    // Levels are held three cycles, longer than the one-cycle minimum
    task automatic drive(input logic p, input logic [3:0] pp);
        @(posedge clock);
        pin <= p;
        port <= pp;
        repeat (3) @(posedge clock);
    endtask

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge clock);
            tick <= 1'b1;
            @(posedge clock);
            tick <= 1'b0;
        end
        repeat (2) @(posedge clock);
    endtask

    task automatic t_reset();
        rd(IFL_EVCTL_OFS, 32'h0, "control reset");
        rd(IFL_OPT_OFS, 32'h40, "edge select reset");
        rd(4'hc, IFL_UNMAPPED_RD, "unmapped read");
        $display("reset test done");
    endtask

    task automatic t_edge();
        for (int s = 1; s >= 0; s--)
        begin
            wb(1'b1, IFL_OPT_OFS, {1'b0, s[0], 6'h0});
            drive(~s[0], port);
            wb(1'b1, IFL_EVCTL_OFS, 8'h00);
            drive(s[0], port);
            rd(IFL_EVCTL_OFS, 32'h2, "qualifying edge");
            check({31'h0, irq}, 32'h0, "disabled pin event");
            wb(1'b1, IFL_EVCTL_OFS, 8'h00);
            drive(~s[0], port);
            rd(IFL_EVCTL_OFS, 32'h0, "opposite edge");
        end
        $display("edge test done");
    endtask

    task automatic t_irq();
        wb(1'b1, IFL_OPT_OFS, 8'h40);
        drive(1'b0, port);
        wb(1'b1, IFL_EVCTL_OFS, 8'h10);
        drive(1'b1, port);
        check({31'h0, irq}, 32'h0, "global gate");
        wb(1'b1, IFL_EVCTL_OFS, 8'h92);
        check({31'h0, irq}, 32'h1, "request");
        accept <= 1'b1;
        repeat (3) @(posedge clock);
        accept <= 1'b0;
        check({31'h0, irq}, 32'h0, "vector entry");
        rd(IFL_EVCTL_OFS, 32'h12, "flag held");
        wb(1'b1, IFL_EVCTL_OFS, 8'h10);
        rd(IFL_EVCTL_OFS, 32'h10, "flag cleared");
        $display("request test done");
    endtask

    task automatic t_timer();
        wb(1'b1, IFL_EVCTL_OFS, 8'h80);
        ticks(255);
        rd(IFL_STAT_OFS, {16'h0, IFL_TMR_MAX, 8'h01}, "count at max");
        rd(IFL_EVCTL_OFS, 32'h80, "no wrap yet");
        ticks(1);
        rd(IFL_EVCTL_OFS, 32'h84, "wrap flag");
        check({31'h0, irq}, 32'h0, "wrap disabled");
        wb(1'b1, IFL_EVCTL_OFS, 8'ha4);
        check({31'h0, irq}, 32'h1, "wrap enabled");
        $display("timer test done");
    endtask

    task automatic t_port();
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b1, IFL_EVCTL_OFS, 8'h00);
            drive(1'b1, port ^ (4'h1 << i));
            rd(IFL_EVCTL_OFS, 32'h1, "port change");
        end
        check({31'h0, irq}, 32'h0, "port disabled");
        wb(1'b1, IFL_EVCTL_OFS, 8'h89);
        check({31'h0, irq}, 32'h1, "port enabled");
        rd(IFL_STAT_OFS, 32'h9f, "pending status");
        $display("port test done");
    endtask

    // The last case never wakes, so it closes the run
    task automatic t_sleep();
        int w0;
        for (int k = 0; k < 3; k++)
        begin
            drive(1'b0, port);
            wb(1'b1, IFL_EVCTL_OFS, k == 0 ? 8'h10 : (k == 1 ? 8'h90 : 8'h00));
            wb(1'b1, IFL_OPT_OFS, 8'h41);
            w0 = wakes;
            @(posedge clock);
            check({30'h0, sleeping, irq}, 32'h2, "asleep");
            drive(1'b1, port);
            repeat (5) @(posedge clock);
            check({30'h0, wakes != w0, (wakes != w0) & woke_vec},
                k == 0 ? 2 : (k == 1 ? 3 : 0), "wake");
        end
        $display("sleep test done");
    endtask

    initial
    begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_edge();
        t_irq();
        t_timer();
        t_port();
        t_sleep();
        wrap_up();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        wrap_up();
    end
endmodule
